// ===== rtl/wtr_pkg.sv
// shared constants for the watchdog timer and reset block
package wtr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_WATCHDOG_COUNT = 8'hff;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h90;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h91;

  ////////////////////////////////////////////////////////////////////////////
  // power control fields and reset values
  localparam int PC_LOAD_EN_BIT = 4;
  localparam int PC_POWER_DOWN_BIT = 1;
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status layout
  localparam int ST_W = 3;
  localparam int ST_OVERFLOW = 0;
  localparam int ST_PD_REFUSED = 1;
  localparam int ST_LOAD_REFUSED = 2;
  localparam logic [ST_W-1:0] ST_RESET = 3'h0;
  localparam logic [ST_W-1:0] MASK_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLOCK_HZ = 25000000;
  localparam int OSC_DIV = 6;
  localparam int PRESCALE_BITS = 11;
  localparam int MACHINE_CYCLE_CLKS = 6;
  localparam int EXT_PULSE_MC = 3;
  localparam int EXT_PULSE_CLKS = EXT_PULSE_MC * MACHINE_CYCLE_CLKS;
  localparam int INT_PULSE_MC = 1;
  localparam int INT_PULSE_CLKS = INT_PULSE_MC * MACHINE_CYCLE_CLKS;
  localparam int SEQ_CNT_W = 5;

  typedef enum logic [1:0] {RS_RUN, RS_INT, RS_EXT} wtr_rst_state_t;

endpackage

// ===== rtl/wtr_prescaler.sv
// divide-by-six feed and prescaler that paces the watchdog count
`timescale 1ns/1ns
module wtr_prescaler #(
  parameter int PRESCALE_BITS = wtr_pkg::PRESCALE_BITS
) (
  // clock
  input wire logic clock,
  // tick link to the core
  wtr_tick_if.src tk
);
  localparam int PERIOD = wtr_pkg::OSC_DIV * (2 ** PRESCALE_BITS);
  localparam int GAP_W = PRESCALE_BITS + 3;
  localparam logic [2:0] DIV_LAST = 3'(wtr_pkg::OSC_DIV - 1);

  logic [2:0] div;
  logic [PRESCALE_BITS-1:0] pre;
  logic feed;
  logic [GAP_W-1:0] gap;
  logic seen;

  ////////////////////////////////////////////////////////////////////////////
  // feed at one sixth of the oscillator, then the prescaler wrap
  assign feed = tk.run && (div == DIV_LAST);
  assign tk.tick = feed && (&pre);

  always_ff @(posedge clock) begin
    if (tk.clear) begin
      div <= 3'h0;
      pre <= '0;
    end else if (tk.run) begin
      div <= feed ? 3'h0 : div + 3'h1;
      if (feed) begin
        pre <= pre + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers
  always_ff @(posedge clock) begin
    if (tk.clear) begin
      gap <= '0;
      seen <= 1'b0;
    end else if (tk.tick) begin
      gap <= '0;
      seen <= 1'b1;
    end else if (tk.run) begin
      gap <= gap + 1'b1;
    end
  end

  a_tick_spacing: assert property (@(posedge clock) disable iff (tk.clear)
    (tk.tick && seen) |-> (gap == GAP_W'(PERIOD - 1)))
    else $error("tick spacing wrong");

endmodule // wtr_prescaler

// ===== rtl/wtr_tick_if.sv
// tick handshake between the watchdog core and its prescaler
`timescale 1ns/1ns
interface wtr_tick_if;
  logic run;
  logic clear;
  logic tick;
  modport src (input run, input clear, output tick);
  modport sink (output run, output clear, input tick);
endinterface

// ===== rtl/wtr_watchdog.sv
// watchdog timer with reload guard, reset pulse generator and power-down lock
`timescale 1ns/1ns

// Behaviour
// - the watchdog is an 8-bit counter advanced by an 11-bit prescaler.
// - the prescaler is fed at one sixth of the clock rate.
// - the counter advances once per 6 times 2048 clocks, one prescaler wrap.
// - counter overflow raises a short internal reset of the whole system.
// - overflow also drives the reset pin for three machine cycles.
// - a low enable pin turns the watchdog on and software cannot turn it off.
// - a counter write is taken only while the load enable flag is set.
// - the load enable flag clears itself when the counter is loaded.
// - a counter write with the flag clear is ignored.
// - the counter counts up from the loaded value to overflow.
// - prescaler and counter keep running in idle mode.
// - while enabled, the power-down bit cannot be set and stays zero.
// - with the enable pin high the watchdog never overflows.
module wtr_watchdog #(
  parameter int PRESCALE_BITS = wtr_pkg::PRESCALE_BITS
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port
  input wire logic [wtr_pkg::ADDR_W-1:0] ADDR,
  input wire logic [wtr_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [wtr_pkg::DATA_W-1:0] RDATA,
  // enable pin, active low
  input wire logic WATCHDOG_ENABLE_N_PIN,
  // reset outputs
  output logic SYS_RESET,
  output logic RST_PIN_DRIVE,
  output logic RST_PIN_OE,
  // power control and interrupt
  output logic POWER_DOWN,
  output logic IRQ
);

  localparam logic [wtr_pkg::SEQ_CNT_W-1:0] INT_LAST =
    wtr_pkg::SEQ_CNT_W'(wtr_pkg::INT_PULSE_CLKS - 1);
  localparam logic [wtr_pkg::SEQ_CNT_W-1:0] EXT_LAST =
    wtr_pkg::SEQ_CNT_W'(wtr_pkg::EXT_PULSE_CLKS - 1);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic ew_meta;
  logic ew_sync;
  logic enabled;
  logic soft_rst;
  logic [7:0] power_control;
  logic [7:0] next_power_control;
  logic [7:0] count;
  logic [7:0] next_count;
  logic [wtr_pkg::ST_W-1:0] status;
  logic [wtr_pkg::ST_W-1:0] next_status;
  logic [wtr_pkg::ST_W-1:0] mask;
  logic [wtr_pkg::ST_W-1:0] events;
  logic [7:0] rdata;
  logic [7:0] rd_mux;
  logic sys_reset;
  logic rst_drive;
  wtr_pkg::wtr_rst_state_t state;
  wtr_pkg::wtr_rst_state_t next_state;
  logic [wtr_pkg::SEQ_CNT_W-1:0] seq_cnt;
  logic [wtr_pkg::SEQ_CNT_W-1:0] next_seq_cnt;
  logic sel_power_control;
  logic sel_count;
  logic sel_status;
  logic sel_mask;
  logic wr_power_control;
  logic wr_count;
  logic wr_mask;
  logic rd_status;
  logic load_en;
  logic load_now;
  logic load_refused;
  logic pd_refused;
  logic tick;
  logic overflow;

  wtr_tick_if tk ();

  ////////////////////////////////////////////////////////////////////////////
  // enable pin synchroniser; reads as disabled until the pin settles
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ew_meta <= 1'b1;
      ew_sync <= 1'b1;
    end else begin
      ew_meta <= WATCHDOG_ENABLE_N_PIN;
      ew_sync <= ew_meta;
    end
  end

  // no software bit takes part: only the pin decides
  assign enabled = !ew_sync;

  // the watchdog's own reset clears power control, count and prescaler; status, mask and sequencer clear only on RST
  assign soft_rst = RST || sys_reset;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign sel_power_control = hit(ADDR, wtr_pkg::ADDR_POWER_CONTROL);
  assign sel_count = hit(ADDR, wtr_pkg::ADDR_WATCHDOG_COUNT);
  assign sel_status = hit(ADDR, wtr_pkg::ADDR_IRQ_STATUS);
  assign sel_mask = hit(ADDR, wtr_pkg::ADDR_IRQ_MASK);

  // power control and count writes during the internal reset pulse are lost, as in the rest of the chip; mask writes still land
  assign wr_power_control = WR && sel_power_control && !sys_reset;
  assign wr_count = WR && sel_count && !sys_reset;
  assign wr_mask = WR && sel_mask;
  assign rd_status = RD && sel_status;

  ////////////////////////////////////////////////////////////////////////////
  // two-step reload
  assign load_en = power_control[wtr_pkg::PC_LOAD_EN_BIT];
  assign load_now = wr_count && load_en;
  assign load_refused = wr_count && !load_en;
  assign pd_refused = wr_power_control && WDATA[wtr_pkg::PC_POWER_DOWN_BIT] && enabled;

  always_comb begin
    next_power_control = power_control;
    if (wr_power_control) begin
      next_power_control = WDATA;
    end
    if (load_now) begin
      next_power_control[wtr_pkg::PC_LOAD_EN_BIT] = 1'b0;
    end
    // also drops a power-down bit that was set before the pin went low
    if (enabled) begin
      next_power_control[wtr_pkg::PC_POWER_DOWN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (soft_rst) begin
      power_control <= wtr_pkg::PC_RESET;
    end else begin
      power_control <= next_power_control;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler; there is no idle input, so idle mode never stalls it
  assign tk.run = enabled;
  assign tk.clear = soft_rst;
  assign tick = tk.tick;

  wtr_prescaler #(
    .PRESCALE_BITS(PRESCALE_BITS)
  ) u_prescaler (
    .clock(CLOCK),
    .tk(tk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter; a load in the same cycle as a tick wins and swallows the tick
  assign overflow = tick && enabled && !load_now && (count == wtr_pkg::COUNT_TOP) &&
    (state == wtr_pkg::RS_RUN);

  always_comb begin
    next_count = count;
    if (load_now) begin
      next_count = WDATA;
    end else if (tick && enabled) begin
      next_count = count + 8'h01;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (soft_rst) begin
      count <= wtr_pkg::COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer: internal pulse first, pin pulse runs on to its full length
  always_comb begin
    next_state = state;
    next_seq_cnt = seq_cnt;
    unique case (state)
      wtr_pkg::RS_RUN: begin
        if (overflow) begin
          next_state = wtr_pkg::RS_INT;
          next_seq_cnt = '0;
        end
      end
      wtr_pkg::RS_INT: begin
        next_seq_cnt = seq_cnt + 1'b1;
        if (seq_cnt == INT_LAST) begin
          next_state = wtr_pkg::RS_EXT;
        end
      end
      wtr_pkg::RS_EXT: begin
        next_seq_cnt = seq_cnt + 1'b1;
        if (seq_cnt == EXT_LAST) begin
          next_state = wtr_pkg::RS_RUN;
          next_seq_cnt = '0;
        end
      end
    endcase
  end

  // the sequencer answers only to the external reset, never to its own pulse
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state <= wtr_pkg::RS_RUN;
      seq_cnt <= '0;
      sys_reset <= 1'b0;
      rst_drive <= 1'b0;
    end else begin
      state <= next_state;
      seq_cnt <= next_seq_cnt;
      sys_reset <= (next_state == wtr_pkg::RS_INT);
      rst_drive <= (next_state != wtr_pkg::RS_RUN);
    end
  end

  // a capacitor on the pin may eat this pulse; the internal one is unaffected
  assign SYS_RESET = sys_reset;
  assign RST_PIN_DRIVE = rst_drive;
  assign RST_PIN_OE = rst_drive;
  assign POWER_DOWN = power_control[wtr_pkg::PC_POWER_DOWN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, cleared by reading; survives the watchdog's own reset
  assign events[wtr_pkg::ST_OVERFLOW] = overflow;
  assign events[wtr_pkg::ST_PD_REFUSED] = pd_refused;
  assign events[wtr_pkg::ST_LOAD_REFUSED] = load_refused;
  // set wins over the clear of a read in the same cycle
  assign next_status = (rd_status ? {wtr_pkg::ST_W{1'b0}} : status) | events;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      status <= wtr_pkg::ST_RESET;
      mask <= wtr_pkg::MASK_RESET;
    end else begin
      status <= next_status;
      if (wr_mask) begin
        mask <= WDATA[wtr_pkg::ST_W-1:0];
      end
    end
  end

  assign IRQ = |(status & mask);

  ////////////////////////////////////////////////////////////////////////////
  // read port; unmapped addresses read zero
  assign rd_mux = sel_power_control ? power_control :
                  sel_count ? count :
                  sel_status ? {5'h00, status} :
                  sel_mask ? {5'h00, mask} :
                  8'h00;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata <= 8'h00;
    end else begin
      rdata <= RD ? rd_mux : 8'h00;
    end
  end

  assign RDATA = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  sequence s_int_pulse;
    sys_reset [*6] ##1 !sys_reset;
  endsequence

  sequence s_pin_pulse;
    rst_drive [*8] ##1 rst_drive [*8] ##1 rst_drive [*2] ##1 !rst_drive;
  endsequence

  a_load_taken: assert property ((load_now && !soft_rst) |=> (count == $past(WDATA)))
    else $error("enabled load not taken");

  a_load_autoclear: assert property ((load_now && !soft_rst) |=> !load_en)
    else $error("load enable still set after load");

  a_write_ignored: assert property (
    (wr_count && !load_en && !tick && !soft_rst) |=> $stable(count))
    else $error("unguarded write changed count");

  a_load_flagged: assert property (load_refused |=> status[wtr_pkg::ST_LOAD_REFUSED])
    else $error("refused load not flagged");

  a_count_up: assert property (
    (tick && enabled && !load_now && !soft_rst && count != 8'hff) |=>
    (count == $past(count) + 8'h01))
    else $error("count did not step up");

  a_int_reset: assert property (overflow |=> s_int_pulse)
    else $error("internal reset pulse wrong");

  a_ovf_flagged: assert property (overflow |=> status[wtr_pkg::ST_OVERFLOW])
    else $error("overflow not flagged");

  a_pin_pulse: assert property (overflow |=> s_pin_pulse)
    else $error("reset pin pulse not 18 clocks");

  a_reset_clears: assert property (sys_reset |=> (!load_en && count == 8'h00))
    else $error("watchdog reset left state");

  a_pd_locked: assert property ((enabled && $past(enabled)) |-> !POWER_DOWN)
    else $error("power-down set while enabled");

  a_pd_flagged: assert property (pd_refused |=> status[wtr_pkg::ST_PD_REFUSED])
    else $error("refused power-down not flagged");

  a_no_ovf_off: assert property (
    (!enabled && !load_now && !soft_rst) |=> ($stable(count) && !$rose(sys_reset)))
    else $error("count moved or reset rose while disabled");

  a_run_follows_pin: assert property (tk.run == !ew_sync)
    else $error("prescaler run not tied to pin");

  a_pin_sync: assert property (
    (!$past(RST) && !$past(RST, 2)) |-> (enabled == !$past(WATCHDOG_ENABLE_N_PIN, 2)))
    else $error("enable not two clocks behind the pin");

  a_status_sticky: assert property (
    !rd_status |=> ((status & $past(status)) == $past(status)))
    else $error("status bit dropped without a read");

  a_read_clears: assert property ((rd_status && (events == '0)) |=> (status == '0))
    else $error("status read did not clear");

  a_rdata_idle: assert property (!RD |=> (RDATA == 8'h00))
    else $error("read data outside the read cycle");

endmodule // wtr_watchdog

// ===== test/tb_wtr_watchdog.sv
// self-checking bench for the watchdog timer and reset block
`timescale 1ns/1ns
module tb_wtr_watchdog;
  localparam int PB = 2;
  localparam int TICK = wtr_pkg::OSC_DIV * (1 << PB);

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] raddr;
    logic [7:0] exp;
  } wtr_row_t;

  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic WATCHDOG_ENABLE_N_PIN = 1'b1;
  logic [7:0] RDATA;
  logic SYS_RESET;
  logic RST_PIN_DRIVE;
  logic RST_PIN_OE;
  logic POWER_DOWN;
  logic IRQ;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] d;

  // rows run with the enable pin high, so the count holds still between accesses
  wtr_row_t rows [10] = '{
    '{1'b1, 8'h87, 8'h10, 8'h87, 8'h10},
    '{1'b1, 8'hff, 8'h5a, 8'hff, 8'h5a},
    '{1'b0, 8'h00, 8'h00, 8'h87, 8'h00},
    '{1'b1, 8'hff, 8'h33, 8'hff, 8'h5a},
    '{1'b0, 8'h00, 8'h00, 8'h90, 8'h04},
    '{1'b0, 8'h00, 8'h00, 8'h90, 8'h00},
    '{1'b1, 8'h87, 8'h02, 8'h87, 8'h02},
    '{1'b1, 8'h87, 8'h00, 8'h87, 8'h00},
    '{1'b1, 8'h91, 8'hff, 8'h91, 8'h07},
    '{1'b1, 8'h55, 8'hff, 8'h55, 8'h00}
  };

  wtr_watchdog #(.PRESCALE_BITS(PB)) i_wtr_watchdog (
    .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .WATCHDOG_ENABLE_N_PIN(WATCHDOG_ENABLE_N_PIN),
    .SYS_RESET(SYS_RESET), .RST_PIN_DRIVE(RST_PIN_DRIVE), .RST_PIN_OE(RST_PIN_OE),
    .POWER_DOWN(POWER_DOWN), .IRQ(IRQ)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask

  // read data stand only between the two edges after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(negedge CLOCK);
    v = RDATA;
  endtask

  task automatic pin(input logic v);
    @(posedge CLOCK);
    WATCHDOG_ENABLE_N_PIN <= v;
    repeat (4) @(posedge CLOCK);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CLOCK);
    n_mismatch++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int t0;
    int t1;
    int n_sys;
    int n_pin;
    logic [7:0] prev;
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].raddr, d);
      check("row read", d, rows[i].exp);
    end
    $display("register table done");

    // interrupt raised, masked, unmasked and cleared by a status read
    wr(8'hff, 8'h11);
    @(negedge CLOCK) check("irq raised", IRQ, 8'h01);
    wr(8'h91, 8'h00);
    @(negedge CLOCK) check("irq masked", IRQ, 8'h00);
    wr(8'h91, 8'h04);
    @(negedge CLOCK) check("irq unmasked", IRQ, 8'h01);
    rd(8'h90, d);
    check("status", d, 8'h04);
    check("irq cleared", IRQ, 8'h00);
    $display("interrupt done");

    // load enable is spent by the first of two back-to-back loads
    wr(8'h87, 8'h10);
    wr(8'hff, 8'hf0);
    wr(8'hff, 8'hff);
    rd(8'hff, d);
    check("second load", d, 8'hf0);
    rd(8'h90, d);
    check("double load status", d, 8'h04);
    $display("double load done");

    pin(1'b0);
    wr(8'h87, 8'h02);
    rd(8'h87, d);
    check("power down bit", d, 8'h00);
    check("power down out", POWER_DOWN, 8'h00);
    rd(8'h90, d);
    check("pd refused", d, 8'h02);
    $display("power down lock done");

    // service kept well inside the interval: no overflow may be flagged
    repeat (16) begin
      wr(8'h87, 8'h10);
      wr(8'hff, 8'hfe);
    end
    rd(8'h90, d);
    check("serviced", d, 8'h00);
    $display("service done");

    // step period seen by reading the count every two cycles
    wr(8'h87, 8'h10);
    wr(8'hff, 8'h00);
    rd(8'hff, prev);
    t0 = -1;
    t1 = -1;
    for (int k = 0; k < 60 && t1 < 0; k++) begin
      rd(8'hff, d);
      if (d !== prev) begin
        check("step", d, prev + 8'h01);
        if (t0 < 0) t0 = cyc;
        else t1 = cyc;
      end
      prev = d;
    end
    check("tick period", 8'(t1 - t0), 8'(TICK));
    $display("tick rate done");

    // overflow from ff; flag set again so the watchdog reset must clear it
    wr(8'h87, 8'h10);
    wr(8'hff, 8'hff);
    wr(8'h87, 8'h10);
    for (int k = 0; k < 3 * TICK && SYS_RESET !== 1'b1; k++) @(negedge CLOCK);
    check("overflow seen", SYS_RESET, 8'h01);
    n_sys = 0;
    n_pin = 0;
    for (int k = 0; k < 24; k++) begin
      if (SYS_RESET === 1'b1) n_sys++;
      if (RST_PIN_DRIVE === 1'b1) n_pin++;
      check("pin enable", RST_PIN_OE, 8'(k < 3 * wtr_pkg::MACHINE_CYCLE_CLKS));
      @(negedge CLOCK);
    end
    check("internal pulse", 8'(n_sys), 8'(wtr_pkg::INT_PULSE_CLKS));
    check("pin pulse", 8'(n_pin), 8'(3 * wtr_pkg::MACHINE_CYCLE_CLKS));
    rd(8'h87, d);
    check("flag after reset", d, 8'h00);
    rd(8'hff, d);
    check("count after reset", d, 8'h00);
    rd(8'h90, d);
    check("overflow status", d, 8'h01);
    $display("overflow done");

    pin(1'b1);
    wr(8'h87, 8'h10);
    wr(8'hff, 8'hff);
    n_sys = 0;
    repeat (4 * TICK) begin
      @(negedge CLOCK);
      if (SYS_RESET !== 1'b0) n_sys++;
    end
    check("disabled reset", 8'(n_sys), 8'h00);
    rd(8'hff, d);
    check("disabled count", d, 8'hff);
    wr(8'h87, 8'h02);
    wr(8'hff, 8'h00);
    @(negedge CLOCK) check("power down allowed", POWER_DOWN, 8'h01);
    check("irq before reset", IRQ, 8'h01);
    $display("disabled done");

    @(posedge CLOCK);
    RST <= 1'b1;
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      if (i < 4) begin
        rd(8'h87 + 8'(i == 1) * 8'h78 + 8'(i > 1) * 8'h09 + 8'(i > 2), d);
        check("reset value", d, 8'h00);
      end
    end
    check("reset irq", IRQ, 8'h00);
    check("reset sys", SYS_RESET, 8'h00);
    check("reset pin", RST_PIN_DRIVE, 8'h00);
    check("reset power down", POWER_DOWN, 8'h00);
    $display("reset done");
    stop_test();
  end
endmodule // tb_wtr_watchdog
